/* File: fpcfr_pkg.sv */
// Constants, types and carriers for the control word and fault reporting.
// Assumes one clock domain shared with the host's instruction sequencer.
package fpcfr_pkg;

	// ----------------------------------------------------------------
	// Control word layout
	// ----------------------------------------------------------------
	localparam int          MASK_LSB     = 0;
	localparam int          MASK_MSB     = 5;
	localparam int          INVALID_BIT  = 0;
	localparam int          PREC_LSB     = 8;
	localparam int          PREC_MSB     = 9;
	localparam int          ROUND_LSB    = 10;
	localparam int          ROUND_MSB    = 11;
	localparam int          RSVD_INF_BIT = 12;
	localparam int          NUM_EXC      = 6;
	localparam logic [15:0] CW_INIT      = 16'h033f;
	localparam logic [15:0] CW_RESET     = 16'h033e;
	localparam logic [5:0]  FLAGS_RESET  = 6'h01;

	// ----------------------------------------------------------------
	// Field encodings
	// ----------------------------------------------------------------
	localparam logic [1:0] PREC_24  = 2'h0;
	localparam logic [1:0] PREC_RSV = 2'h1;
	localparam logic [1:0] PREC_53  = 2'h2;
	localparam logic [1:0] PREC_64  = 2'h3;
	localparam logic [6:0] WIDTH_24 = 7'h18;
	localparam logic [6:0] WIDTH_53 = 7'h35;
	localparam logic [6:0] WIDTH_64 = 7'h40;

	typedef enum logic [1:0] {
		FPCFR_RND_NEAREST,
		FPCFR_RND_DOWN,
		FPCFR_RND_UP,
		FPCFR_RND_CHOP
	} fpcfr_round_e;

	// Instruction classes the host hands over
	typedef enum logic [3:0] {
		FPCFR_OP_INIT,
		FPCFR_OP_NOWAIT_INIT,
		FPCFR_OP_LOAD_CW,
		FPCFR_OP_CLEAR_EXC,
		FPCFR_OP_NOWAIT_CLEAR_EXC,
		FPCFR_OP_NOWAIT_STORE_STATUS,
		FPCFR_OP_NOWAIT_STORE_ENV,
		FPCFR_OP_NOWAIT_SAVE,
		FPCFR_OP_WAIT,
		FPCFR_OP_ARITH_PREC,
		FPCFR_OP_ARITH_ROUND,
		FPCFR_OP_ARITH_NOROUND,
		FPCFR_OP_OTHER
	} fpcfr_op_e;

	// ----------------------------------------------------------------
	// Carriers
	// ----------------------------------------------------------------
	typedef struct packed {
		logic        valid;
		fpcfr_op_e   kind;
		logic [15:0] cw_data;
		logic        seg_fault;
	} fpcfr_req_s;

	typedef struct packed {
		logic        valid;
		logic [5:0]  flags;
	} fpcfr_exc_s;

	typedef struct packed {
		logic         valid;
		fpcfr_op_e    kind;
		logic         round_en;
		fpcfr_round_e round_mode_sel;
		logic [6:0]   sig_width;
	} fpcfr_issue_s;

endpackage : fpcfr_pkg

/* File: fpcfr_top.sv */
// Control word and fault reporting of the numeric coprocessor.
// Assumes the host sequencer and the arithmetic unit share ref_clk.
//
// What this block does
// - Control word bits 5..0 mask the six numeric exceptions individually.
// - Bit 12 reserved; cleared by reset and init, loadable by control load.
// - Infinity arithmetic is always affine; no projective option exists.
// - Rounding mode comes from bits 11..10: nearest, two directed, chop.
// - Rounding applies only to ops that round their final result.
// - Significand precision comes from bits 9..8, default 64 bits.
// - Precision control applies only to add, sub, div, mul, sqrt.
// - Segment limit fault: vector 13, and the instruction is not executed.
// - Pending unmasked exception traps only on next opcode or wait.
// - Nowait init, clear, store status, store env, save never trap.
// - Unmasked exception sets its flag, error summary, and the fault output.
// - After reset the fault output is asserted: invalid flag set, unmasked.
`timescale 1ns/1ns
`default_nettype none

module fpcfr_top
	import fpcfr_pkg::*;
(
	// Clock and reset
	input  wire  logic                   ref_clk,
	input  wire  logic                   rst_n,
	// Instruction requests from the host
	input  wire  fpcfr_pkg::fpcfr_req_s  req,
	// Exception report from the arithmetic unit
	input  wire  fpcfr_pkg::fpcfr_exc_s  exc,
	// Register and status view
	output logic [15:0]                  arith_control_word_r,
	output logic [5:0]                   exc_flags_r,
	output logic                         error_summary_r,
	output logic                         fault_n_r,
	// Datapath issue and pending-exception trap
	output fpcfr_pkg::fpcfr_issue_s      issue_r,
	output logic                         pend_trap_r
);
	import fpcfr_pkg::*;

	// ----------------------------------------------------------------
	// Request decode
	// ----------------------------------------------------------------
	// The five nowait forms bypass the pending check; all else waits
	wire logic is_nowait;
	wire logic waits;
	wire logic trap_now;
	wire logic accept;
	wire logic do_init;
	wire logic do_load;
	wire logic do_clear;
	wire logic do_numeric;
	assign is_nowait  = (req.kind == FPCFR_OP_NOWAIT_INIT)
		|| (req.kind == FPCFR_OP_NOWAIT_CLEAR_EXC)
		|| (req.kind == FPCFR_OP_NOWAIT_STORE_STATUS)
		|| (req.kind == FPCFR_OP_NOWAIT_STORE_ENV)
		|| (req.kind == FPCFR_OP_NOWAIT_SAVE);
	assign waits      = req.valid && !req.seg_fault && !is_nowait;
	assign trap_now   = waits && error_summary_r;
	assign accept     = req.valid && !req.seg_fault && !trap_now;
	assign do_init    = accept && ((req.kind == FPCFR_OP_INIT)
		|| (req.kind == FPCFR_OP_NOWAIT_INIT));
	assign do_load    = accept && (req.kind == FPCFR_OP_LOAD_CW);
	assign do_clear   = accept && ((req.kind == FPCFR_OP_CLEAR_EXC)
		|| (req.kind == FPCFR_OP_NOWAIT_CLEAR_EXC));
	assign do_numeric = accept && ((req.kind == FPCFR_OP_ARITH_PREC)
		|| (req.kind == FPCFR_OP_ARITH_ROUND)
		|| (req.kind == FPCFR_OP_ARITH_NOROUND)
		|| (req.kind == FPCFR_OP_OTHER));

	// ----------------------------------------------------------------
	// Control word and status next values
	// ----------------------------------------------------------------
	// Bit 12 is stored but never decoded: infinities are always affine
	wire logic [15:0] cw_nxt;
	wire logic [5:0]  unmasked;
	wire logic [5:0]  flags_nxt;
	wire logic        es_nxt;
	assign cw_nxt    = do_init ? CW_INIT
		: do_load ? req.cw_data : arith_control_word_r;
	assign unmasked  = exc.valid ? (exc.flags
		& ~arith_control_word_r[MASK_MSB:MASK_LSB]) : 6'h00;
	// Set wins over clear: a report in a clearing cycle survives
	assign flags_nxt = ((do_init || do_clear) ? 6'h00 : exc_flags_r)
		| unmasked;
	assign es_nxt    = ((do_init || do_clear) ? 1'b0 : error_summary_r)
		|| (unmasked != 6'h00);

	// ----------------------------------------------------------------
	// Rounding and precision decode for the issued op
	// ----------------------------------------------------------------
	wire logic [1:0]   prec_fld;
	wire logic [6:0]   prec_width;
	wire fpcfr_issue_s issue_nxt;
	assign prec_fld   = arith_control_word_r[PREC_MSB:PREC_LSB];
	// Reserved code falls back to full width rather than guessing
	assign prec_width = (prec_fld == PREC_24) ? WIDTH_24
		: (prec_fld == PREC_53) ? WIDTH_53 : WIDTH_64;
	assign issue_nxt.valid          = do_numeric;
	assign issue_nxt.kind           = req.kind;
	assign issue_nxt.round_en       = do_numeric
		&& ((req.kind == FPCFR_OP_ARITH_PREC)
		|| (req.kind == FPCFR_OP_ARITH_ROUND));
	assign issue_nxt.round_mode_sel = fpcfr_round_e'(
		arith_control_word_r[ROUND_MSB:ROUND_LSB]);
	assign issue_nxt.sig_width      = (req.kind == FPCFR_OP_ARITH_PREC)
		? prec_width : WIDTH_64;

	// ----------------------------------------------------------------
	// State registers
	// ----------------------------------------------------------------
	// Reset announces presence: invalid flag set and its mask clear
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			arith_control_word_r <= CW_RESET;
			exc_flags_r          <= FLAGS_RESET;
			error_summary_r      <= 1'b1;
			fault_n_r            <= 1'b0;
		end else begin
			arith_control_word_r <= cw_nxt;
			exc_flags_r          <= flags_nxt;
			error_summary_r      <= es_nxt;
			fault_n_r            <= !es_nxt;
		end
	end

	// Issue and trap pulses, one cycle each
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			issue_r     <= '0;
			pend_trap_r <= 1'b0;
		end else begin
			issue_r     <= issue_nxt;
			pend_trap_r <= trap_now;
		end
	end

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n);

	AST_MASK_FAULT: assert property (
		(exc.valid && ((exc.flags & ~arith_control_word_r[5:0]) != 6'h00))
		|=> (!fault_n_r && error_summary_r))
		else $error("unmasked exception did not raise fault");
	AST_MASKED_QUIET: assert property (
		(fault_n_r && (!exc.valid || ((exc.flags
		& ~arith_control_word_r[5:0]) == 6'h00)) && !trap_now)
		|=> fault_n_r)
		else $error("fault raised without unmasked exception");
	AST_INIT_CW: assert property (
		do_init |=> (arith_control_word_r == 16'h033f
		&& !arith_control_word_r[12] && fault_n_r == !error_summary_r))
		else $error("init did not restore control word");
	AST_LOAD_CW: assert property (
		do_load |=> (arith_control_word_r == $past(req.cw_data)))
		else $error("control load not stored");
	AST_ROUND_MODE: assert property (
		issue_nxt.valid |=> (issue_r.round_mode_sel
		== $past(arith_control_word_r[11:10])))
		else $error("rounding mode not taken from control word");
	AST_NO_ROUND: assert property (
		(do_numeric && req.kind == FPCFR_OP_ARITH_NOROUND)
		|=> (issue_r.valid && !issue_r.round_en))
		else $error("non-rounding op issued with rounding");
	AST_PREC_WIDTH: assert property (
		(do_numeric && req.kind == FPCFR_OP_ARITH_PREC
		&& arith_control_word_r[9:8] == 2'h0)
		|=> (issue_r.sig_width == 7'h18))
		else $error("24-bit precision not applied");
	AST_PREC_OTHER: assert property (
		(do_numeric && req.kind != FPCFR_OP_ARITH_PREC)
		|=> (issue_r.sig_width == 7'h40))
		else $error("precision applied to wrong op");
	AST_TRAP: assert property (
		(waits && error_summary_r) |=> (pend_trap_r && !issue_r.valid
		&& $stable(arith_control_word_r)))
		else $error("pending exception did not trap");
	AST_NOWAIT: assert property (
		(req.valid && req.kind inside {FPCFR_OP_NOWAIT_INIT,
		FPCFR_OP_NOWAIT_CLEAR_EXC, FPCFR_OP_NOWAIT_STORE_STATUS,
		FPCFR_OP_NOWAIT_STORE_ENV, FPCFR_OP_NOWAIT_SAVE})
		|=> !pend_trap_r)
		else $error("nowait op trapped");
	AST_SEG: assert property (
		(req.valid && req.seg_fault) |=> (!issue_r.valid && !pend_trap_r
		&& $stable(arith_control_word_r)))
		else $error("segment faulted op was executed");
	AST_FAULT_PIN: assert property (
		fault_n_r == !error_summary_r)
		else $error("fault output disagrees with error summary");
	AST_FLAG_SET: assert property (
		(unmasked != 6'h00)
		|=> ((exc_flags_r & $past(unmasked)) == $past(unmasked)))
		else $error("unmasked exception flag not set");
	AST_ROUND_ON: assert property (
		(do_numeric && req.kind == FPCFR_OP_ARITH_ROUND)
		|=> (issue_r.valid && issue_r.round_en
		&& issue_r.sig_width == 7'h40))
		else $error("rounding op issued without rounding");
	AST_PREC_53: assert property (
		(do_numeric && req.kind == FPCFR_OP_ARITH_PREC
		&& arith_control_word_r[9:8] == 2'h2)
		|=> (issue_r.sig_width == 7'h35))
		else $error("53-bit precision not applied");

	COV_TRAP: cover property (error_summary_r && waits ##1 pend_trap_r);
	COV_CLEAR: cover property (!fault_n_r ##1 do_init ##1 fault_n_r);
	COV_ROUND: cover property (issue_r.valid && issue_r.round_en
		&& issue_r.round_mode_sel == FPCFR_RND_CHOP);
	COV_SET_WINS: cover property (do_clear && unmasked != 6'h00);

endmodule : fpcfr_top

`default_nettype wire

/* File: fpcfr_host.sv */
// Host model: issues coprocessor requests and owns the host-side faults.
// Assumes the block samples req on each rising edge of ref_clk.
`timescale 1ns/1ns
`default_nettype none
module fpcfr_host
	import fpcfr_pkg::*;
(
	// Clock
	input  wire logic             ref_clk,
	// Request to the block
	output fpcfr_pkg::fpcfr_req_s req
);
	logic software_fp_fallback = 1'b0;
	logic task_switched_flag   = 1'b0;
	int   n_vec7               = 0;
	int   n_vec13              = 0;
	int   n_vec9               = 0;
	int   seq                  = 0;
	int   num_ip               = 0;
	initial req = '0;
	// Caller sits at a falling edge; request stands over one rising edge
	task automatic send(input fpcfr_op_e k, input logic [15:0] d,
		input logic seg);
		if (task_switched_flag ||
			(software_fp_fallback && k != FPCFR_OP_WAIT)) begin
			n_vec7++;
			req.valid <= 1'b0;
			@(negedge ref_clk);
			return;
		end
		n_vec13 += int'(seg);
		seq++;
		// Pointers keep naming the last numeric op, not control ops
		if (!seg && k inside {FPCFR_OP_ARITH_PREC, FPCFR_OP_ARITH_ROUND,
			FPCFR_OP_ARITH_NOROUND, FPCFR_OP_OTHER})
			num_ip = seq;
		req <= '{1'b1, k, d, seg};
		@(negedge ref_clk);
	endtask : send
	// Released data is scrambled so stale values cannot pass as good
	task automatic idle();
		req.valid   <= 1'b0;
		req.cw_data <= ~req.cw_data;
		@(negedge ref_clk);
	endtask : idle
	// Operand wrap: vector 9, handled by a nowait init
	task automatic overrun();
		n_vec9++;
		send(FPCFR_OP_NOWAIT_INIT, 16'h0, 1'b0);
	endtask : overrun
endmodule : fpcfr_host
`default_nettype wire

/* File: fp_control_and_fault_report_tb.sv */
// Self-checking bench for the control word and fault reporting block.
// Assumes the host model drives req; the bench plays the arithmetic unit.
`timescale 1ns/1ns
`default_nettype none
module fp_control_and_fault_report_tb;
	import fpcfr_pkg::*;
	logic         ref_clk    = 1'b0;
	logic         rst_n      = 1'b0;
	fpcfr_exc_s   exc        = '0;
	fpcfr_req_s   req;
	fpcfr_issue_s iss;
	logic [15:0]  cw;
	logic [5:0]   flg;
	logic         es;
	logic         fault_n;
	logic         trap;
	logic [14:0]  expq[$];
	int           n_mismatch = 0;
	int           checks     = 0;
	always #5 ref_clk = ~ref_clk;
	fpcfr_host h (.ref_clk(ref_clk), .req(req));
	fpcfr_top dut (.ref_clk(ref_clk), .rst_n(rst_n), .req(req), .exc(exc),
		.arith_control_word_r(cw), .exc_flags_r(flg), .error_summary_r(es),
		.fault_n_r(fault_n), .issue_r(iss), .pend_trap_r(trap));
	// Mode is only meaningful when rounding is enabled
	function automatic logic [14:0] ev(logic r, logic [3:0] k,
		logic [1:0] m, logic [6:0] w);
		return {1'b0, k, r, r ? m : 2'h0, w};
	endfunction : ev
	task automatic cmp_reg(input logic [15:0] got, input logic [15:0] exp,
		input string what);
		checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask : cmp_reg
	task automatic cmp_ev(input logic [14:0] got, input logic [14:0] exp);
		cmp_reg({1'b0, got}, {1'b0, exp}, "event");
	endtask : cmp_ev
	task automatic chk(input logic [15:0] c, input logic [5:0] f,
		input logic e);
		cmp_reg(cw, c, "cw");
		cmp_reg({10'h0, flg}, {10'h0, f}, "flags");
		cmp_reg({14'h0, es, fault_n}, {14'h0, e, !e}, "summary");
	endtask : chk
	task automatic op(input fpcfr_op_e k, input logic [15:0] d,
		input logic [14:0] e);
		if (e != 15'h0) expq.push_back(e);
		h.send(k, d, 1'b0);
	endtask : op
	task automatic summarize();
		$display("checks %0d n_mismatch %0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : summarize
	// Result watcher: an unexpected result meets a poisoned note
	always @(negedge ref_clk) begin
		if (trap === 1'b1 || iss.valid === 1'b1) begin
			if (expq.size() == 0) expq.push_back(15'h7fff);
			cmp_ev(trap ? 15'h4000 : ev(iss.round_en, iss.kind,
				iss.round_mode_sel, iss.sig_width), expq.pop_front());
		end
	end
	// Watchdog far beyond the fewer than 150 cycles the tests take
	initial begin
		#100000;
		n_mismatch++;
		summarize();
	end
	initial begin : main
		logic [15:0] d;
		logic [5:0]  m;
		logic [5:0]  f;
		logic [6:0]  w;
		void'($urandom(32'h6f9e));
		repeat (20) @(negedge ref_clk);
		rst_n = 1'b1;
		chk(CW_RESET, FLAGS_RESET, 1'b1);
		op(FPCFR_OP_NOWAIT_STORE_STATUS, 16'h0, 15'h0);
		op(FPCFR_OP_NOWAIT_STORE_ENV, 16'h0, 15'h0);
		op(FPCFR_OP_NOWAIT_SAVE, 16'h0, 15'h0);
		op(FPCFR_OP_WAIT, 16'h0, 15'h4000);
		op(FPCFR_OP_ARITH_ROUND, 16'h0, 15'h4000);
		op(FPCFR_OP_LOAD_CW, 16'h0, 15'h4000);
		op(FPCFR_OP_NOWAIT_CLEAR_EXC, 16'h0, 15'h0);
		h.idle();
		chk(CW_RESET, 6'h00, 1'b0);
		$display("test reset_trap done");
		d = 16'($urandom) | 16'h1000;
		h.send(FPCFR_OP_LOAD_CW, d, 1'b1);
		h.idle();
		chk(CW_RESET, 6'h00, 1'b0);
		op(FPCFR_OP_LOAD_CW, d, 15'h0);
		h.idle();
		chk(d, 6'h00, 1'b0);
		op(FPCFR_OP_INIT, 16'h0, 15'h0);
		h.idle();
		chk(CW_INIT, 6'h00, 1'b0);
		h.task_switched_flag = 1'b1;
		op(FPCFR_OP_WAIT, 16'h0, 15'h0);
		h.task_switched_flag   = 1'b0;
		h.software_fp_fallback = 1'b1;
		op(FPCFR_OP_ARITH_ROUND, 16'h0, 15'h0);
		op(FPCFR_OP_WAIT, 16'h0, 15'h0);
		h.software_fp_fallback = 1'b0;
		h.idle();
		chk(CW_INIT, 6'h00, 1'b0);
		cmp_reg(16'(h.n_vec7), 16'h2, "vector 7");
		cmp_reg(16'(h.n_vec13), 16'h1, "vector 13");
		$display("test load_init done");
		for (int i = 0; i < 16; i++) begin
			d = {4'h0, i[1:0], i[3:2], 8'h3f};
			w = (i[3:2] == PREC_24) ? WIDTH_24 :
				(i[3:2] == PREC_53) ? WIDTH_53 : WIDTH_64;
			op(FPCFR_OP_LOAD_CW, d, 15'h0);
			op(FPCFR_OP_ARITH_PREC, 16'h0, ev(1'b1, FPCFR_OP_ARITH_PREC,
				i[1:0], w));
			op(FPCFR_OP_ARITH_ROUND, 16'h0, ev(1'b1, FPCFR_OP_ARITH_ROUND,
				i[1:0], WIDTH_64));
			op(FPCFR_OP_ARITH_NOROUND, 16'h0, ev(1'b0,
				FPCFR_OP_ARITH_NOROUND, 2'h0, WIDTH_64));
		end
		op(FPCFR_OP_OTHER, 16'h0, ev(1'b0, FPCFR_OP_OTHER, 2'h0,
			WIDTH_64));
		cmp_reg(16'(h.seq - h.num_ip), 16'h0, "pointer");
		op(FPCFR_OP_NOWAIT_STORE_ENV, 16'h0, 15'h0);
		cmp_reg(16'(h.seq - h.num_ip), 16'h1, "pointer");
		h.idle();
		$display("test round_prec done");
		for (int j = 0; j < 8; j++) begin
			m = 6'($urandom);
			f = 6'($urandom);
			op(FPCFR_OP_NOWAIT_CLEAR_EXC, 16'h0, 15'h0);
			op(FPCFR_OP_LOAD_CW, {10'h00c, m}, 15'h0);
			exc <= '{1'b1, f};
			// Odd passes clear in the report cycle: the report must survive
			if (j[0]) h.send(FPCFR_OP_CLEAR_EXC, 16'h0, 1'b0);
			else h.idle();
			exc <= '{1'b0, ~f};
			h.idle();
			chk({10'h00c, m}, f & ~m, |(f & ~m));
			if (|(f & ~m)) op(FPCFR_OP_ARITH_PREC, 16'h0, 15'h4000);
		end
		h.idle();
		h.overrun();
		h.idle();
		chk(CW_INIT, 6'h00, 1'b0);
		cmp_reg(16'(h.n_vec9), 16'h1, "vector 9");
		$display("test exceptions done");
		cmp_reg(16'(expq.size()), 16'h0, "missing results");
		summarize();
	end
endmodule : fp_control_and_fault_report_tb
`default_nettype wire
